// >>> common/jpdr_pkg.sv
package jpdr_pkg;
  localparam logic [3:0]  JPDR_IR_UNLOCK   = 4'h4;
  localparam logic [3:0]  JPDR_IR_COMMAND  = 4'h5;
  localparam logic [3:0]  JPDR_IR_PLOAD    = 4'h6;
  localparam logic [3:0]  JPDR_IR_PREAD    = 4'h7;
  localparam logic [3:0]  JPDR_IR_RESET    = 4'hC;
  localparam int          JPDR_CMD_W       = 15;
  localparam int          JPDR_EN_W        = 16;
  localparam logic [15:0] JPDR_SIGNATURE   = 16'hA370;
  localparam logic [15:0] JPDR_EN_RESET    = 16'h0000;
  localparam int          JPDR_PAGE_BITS   = 1024;
  localparam int          JPDR_PAGE_BYTES  = JPDR_PAGE_BITS / 8;
  localparam int          JPDR_READ_BITS   = JPDR_PAGE_BITS + 8;
  localparam int          JPDR_FIFO_DEPTH  = 16;
  // Reset time-out lengths for each fuse selection, in microseconds.
  localparam int          JPDR_TOUT0_US    = 0;
  localparam int          JPDR_TOUT1_US    = 4100;
  localparam int          JPDR_TOUT2_US    = 65000;
  localparam int          JPDR_CLK_MHZ     = 100;
  localparam int          JPDR_TOUT1_CYC   = JPDR_TOUT1_US * JPDR_CLK_MHZ;
  localparam int          JPDR_TOUT2_CYC   = JPDR_TOUT2_US * JPDR_CLK_MHZ;

  // TAP controller state strobes seen by the data registers.
  typedef struct packed {
    logic       capture_dr;
    logic       shift_dr;
    logic       update_dr;
    logic       run_idle;
    logic [3:0] instr;
  } jpdr_tap_t;

  // One page byte moving into the page buffer.
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } jpdr_byte_t;
endpackage

// >>> core/jpdr_core.sv
`timescale 1ns/1ns
`default_nettype none
module jpdr_core import jpdr_pkg::*; #(
  parameter int TOUT1_CYC = JPDR_TOUT1_CYC,
  parameter int TOUT2_CYC = JPDR_TOUT2_CYC
) (
  // Clock, power-on reset and enable.
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Scan pins and TAP state from the controller.
  input  wire logic             tck,
  input  wire logic             tdi,
  input  wire jpdr_tap_t        tap,
  output logic                  tdo,
  output logic                  tdo_oe,
  // Clock-option fuse selection for the reset time-out.
  input  wire logic [1:0]       tout_sel,
  // Command path to the memory controller.
  output logic                  cmd_valid,
  input  wire logic             cmd_ready,
  output logic [JPDR_CMD_W-1:0] cmd_data,
  output logic                  cmd_exec,
  input  wire logic [JPDR_CMD_W-1:0] cmd_result,
  // Page buffer access.
  output logic                  pg_wr,
  output logic                  pg_rd,
  output jpdr_byte_t            pg_wbyte,
  output logic [6:0]            pg_raddr,
  input  wire logic [7:0]       pg_rdata,
  // Device state.
  output logic                  core_reset,
  output logic                  prog_enabled
);
  typedef struct packed {
    logic [2:0]            tck_sync;
    logic [1:0]            tdi_sync;
    logic                  prev_upd;
    logic                  prev_idle;
    logic                  prev_cap;
    logic [JPDR_CMD_W-1:0] cmd_sh;
    logic [JPDR_EN_W-1:0]  en_sh;
    logic                  prog_en;
    logic                  rst_bit;
    logic [7:0]            pg_sh;
    logic [2:0]            bit_cnt;
    logic [6:0]            byte_addr;
    logic                  lost;
    logic [31:0]           tout_cnt;
    logic                  tdo_bit;
    logic                  exec;
    logic                  wr;
    jpdr_byte_t            wbyte;
  } jpdr_st_t;

  jpdr_st_t st_r;
  jpdr_st_t st_nxt;
  logic     tck_rise;
  logic     tck_fall;
  logic     tdi_s;
  logic     fifo_ready;
  logic [31:0] tout_len;

  // Only the second and third stages are looked at; the first settles.
  assign tck_rise = st_r.tck_sync[1] & ~st_r.tck_sync[2];
  assign tck_fall = ~st_r.tck_sync[1] & st_r.tck_sync[2];
  assign tdi_s    = st_r.tdi_sync[1];

  always_comb begin
    unique case (tout_sel)
      2'b00:   tout_len = 32'(JPDR_TOUT0_US * JPDR_CLK_MHZ);
      2'b01:   tout_len = 32'(TOUT1_CYC);
      default: tout_len = 32'(TOUT2_CYC);
    endcase
  end

  // All data-register work happens on detected TCK edges.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.tck_sync = {st_r.tck_sync[1:0], tck};
    st_nxt.tdi_sync = {st_r.tdi_sync[0], tdi};
    st_nxt.exec     = 1'b0;
    st_nxt.wr       = 1'b0;
    if (tck_rise) begin
      st_nxt.prev_upd  = tap.update_dr;
      st_nxt.prev_idle = tap.run_idle;
      st_nxt.prev_cap  = tap.capture_dr;
      unique case (tap.instr)
        JPDR_IR_COMMAND: begin
          if (tap.capture_dr) begin
            st_nxt.cmd_sh = cmd_result;
          end
          if (tap.shift_dr) begin
            st_nxt.cmd_sh = {tdi_s, st_r.cmd_sh[JPDR_CMD_W-1:1]};
          end
          // One execute pulse on entering Run-Test/Idle.
          if (tap.run_idle && !st_r.prev_idle) begin
            st_nxt.exec = 1'b1;
          end
          // A command that meets a full FIFO is dropped and never executed.
          if (tap.update_dr && !st_r.prev_upd) begin
            st_nxt.lost = ~fifo_ready;
          end
        end
        JPDR_IR_UNLOCK: begin
          if (tap.shift_dr) begin
            st_nxt.en_sh = {tdi_s, st_r.en_sh[JPDR_EN_W-1:1]};
          end
          if (tap.update_dr && !st_r.prev_upd) begin
            st_nxt.prog_en = (st_r.en_sh == JPDR_SIGNATURE);
          end
        end
        JPDR_IR_PLOAD: begin
          if (tap.capture_dr) begin
            st_nxt.bit_cnt   = '0;
            st_nxt.byte_addr = '0;
          end
          // Update-DR moves nothing here; full bytes leave on their own.
          if (tap.shift_dr) begin
            st_nxt.pg_sh   = {tdi_s, st_r.pg_sh[7:1]};
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == 3'h7) begin
              st_nxt.wr         = 1'b1;
              st_nxt.wbyte.addr = st_r.byte_addr;
              st_nxt.wbyte.data = {tdi_s, st_r.pg_sh[7:1]};
              st_nxt.byte_addr  = st_r.byte_addr + 7'h01;
            end
          end
        end
        JPDR_IR_PREAD: begin
          // The first eight bits of the chain are a fill byte.
          if (tap.capture_dr) begin
            st_nxt.bit_cnt   = '0;
            st_nxt.byte_addr = '0;
            st_nxt.pg_sh     = 8'h00;
          end
          if (tap.shift_dr) begin
            st_nxt.pg_sh   = {1'b0, st_r.pg_sh[7:1]};
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == 3'h7) begin
              st_nxt.pg_sh     = pg_rdata;
              // The byte is in hand, so the next address may go out now.
              st_nxt.byte_addr = st_r.byte_addr + 7'h01;
            end
          end
        end
        JPDR_IR_RESET: begin
          if (tap.shift_dr) begin
            st_nxt.rst_bit = tdi_s;
          end
        end
        default: begin
        end
      endcase
    end
    // TDO changes on the falling edge, as the scan host expects.
    if (tck_fall) begin
      unique case (tap.instr)
        JPDR_IR_COMMAND: st_nxt.tdo_bit = st_r.cmd_sh[0];
        JPDR_IR_UNLOCK:  st_nxt.tdo_bit = st_r.en_sh[0];
        JPDR_IR_PLOAD:   st_nxt.tdo_bit = st_r.pg_sh[0];
        JPDR_IR_PREAD:   st_nxt.tdo_bit = st_r.pg_sh[0];
        JPDR_IR_RESET:   st_nxt.tdo_bit = st_r.rst_bit;
        default:         st_nxt.tdo_bit = 1'b0;
      endcase
    end
    // The time-out reloads while the reset bit is high and then counts down.
    if (st_r.rst_bit) begin
      st_nxt.tout_cnt = tout_len;
    end else if (st_r.tout_cnt != '0) begin
      st_nxt.tout_cnt = st_r.tout_cnt - 32'h1;
    end
  end

  // Power-on reset clears the unlock state and all shifters.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.prog_en <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Update-DR latches the command into a FIFO toward the memory side.
  jpdr_fifo #(
    .WIDTH (JPDR_CMD_W),
    .DEPTH (JPDR_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (tck_rise & tap.update_dr & ~st_r.prev_upd &
                (tap.instr == JPDR_IR_COMMAND)),
    .in_ready  (fifo_ready),
    .in_data   (st_r.cmd_sh),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_data)
  );

  // A dropped command gets no execute pulse; the host must poll busy.
  assign tdo          = st_r.tdo_bit;
  assign tdo_oe       = tap.shift_dr;
  assign cmd_exec     = st_r.exec & ~st_r.lost;
  assign pg_wr        = st_r.wr;
  assign pg_wbyte     = st_r.wbyte;
  assign pg_rd        = tap.shift_dr & (tap.instr == JPDR_IR_PREAD);
  assign pg_raddr     = st_r.byte_addr;
  // Reset follows the bit with no update stage in between.
  assign core_reset   = st_r.rst_bit | (st_r.tout_cnt != '0);
  assign prog_enabled = st_r.prog_en;
endmodule
`default_nettype wire

// >>> core/jpdr_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module jpdr_fifo import jpdr_pkg::*; #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } jpdr_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  jpdr_fifo_st_t    st_r;
  jpdr_fifo_st_t    st_nxt;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = mem[st_r.rp];
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;

  // Pointer arithmetic wraps on a power-of-two depth.
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage has no reset; only the pointers and the count need a known value.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[st_r.wp] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/jpdr_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
module jpdr_props import jpdr_pkg::*; #(
  parameter int TOUT1_CYC = 20,
  parameter int TOUT2_CYC = 40
) (
  // Clock and power-on reset.
  input wire logic            clk_sys,
  input wire logic            reset_n,
  // Scan side.
  input wire logic            tck,
  input wire jpdr_tap_t       tap,
  input wire logic            tdo,
  input wire logic            tdo_oe,
  // Memory side.
  input wire logic            cmd_valid,
  input wire logic            cmd_ready,
  input wire logic [14:0]     cmd_data,
  input wire logic            cmd_exec,
  input wire logic            pg_wr,
  input wire logic            pg_rd,
  input wire logic            prog_enabled
);
  // Every check runs on the system clock and rests while reset is low.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_oe; tdo_oe == tap.shift_dr; endproperty
  a_oe: assert property (p_oe) else $error("tdo enable off shift");
  property p_tdo; $changed(tdo) |-> !tck; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved at tck high");
  property p_unl;
    $changed(prog_enabled) |-> tap.update_dr && tap.instr == JPDR_IR_UNLOCK;
  endproperty
  a_unl: assert property (p_unl) else $error("enable moved off update");
  property p_exe;
    cmd_exec |-> (tap.run_idle && tap.instr == JPDR_IR_COMMAND) ##1 !cmd_exec;
  endproperty
  a_exe: assert property (p_exe) else $error("bad execute pulse");
  property p_pgw;
    pg_wr |-> (tap.shift_dr && tap.instr == JPDR_IR_PLOAD) ##1 !pg_wr;
  endproperty
  a_pgw: assert property (p_pgw) else $error("bad page write");
  property p_pgr; pg_rd |-> tap.instr == JPDR_IR_PREAD; endproperty
  a_pgr: assert property (p_pgr) else $error("page fetch off read");
  property p_cmv;
    $rose(cmd_valid) |-> tap.update_dr && tap.instr == JPDR_IR_COMMAND;
  endproperty
  a_cmv: assert property (p_cmv) else $error("command off update");
  property p_hld;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data);
  endproperty
  a_hld: assert property (p_hld) else $error("command dropped");
endmodule
bind jpdr_core jpdr_props #(.TOUT1_CYC(TOUT1_CYC), .TOUT2_CYC(TOUT2_CYC))
  u_props (.clk_sys, .reset_n, .tck, .tap, .tdo, .tdo_oe, .cmd_valid,
  .cmd_ready, .cmd_data, .cmd_exec, .pg_wr, .pg_rd, .prog_enabled);
`default_nettype wire

// >>> testbench/jpdr_host.sv
`timescale 1ns/1ns
`default_nettype none
// Scan host; it is alone on the chain, so the device is first.
module jpdr_host import jpdr_pkg::*; (
  // Scan pins toward the device.
  output var logic      tck,
  output var logic      tdi,
  output var jpdr_tap_t tap,
  // Scan data from the device.
  input  wire logic     tdo
);
  // The scan clock stands still between frames.
  initial begin
    tck = 1'h0;
    tdi = 1'h0;
    tap = '0;
  end
  // One 160 ns scan period; levels only change while tck is low.
  task automatic pulse(output logic smp);
    #80 tck = 1'h1;
    smp = tdo;
    #80 tck = 1'h0;
  endtask
  // Capture, n shifts, exit and optional update.
  // Each state is set by one assignment, so no step writes tap twice.
  task automatic scan(input logic [3:0] ir, input int n, input logic upd,
                      input logic [1039:0] din, output logic [1039:0] dout);
    logic      s;
    jpdr_tap_t t;
    t = '0;
    t.instr = ir;
    t.capture_dr = 1'h1;
    tap = t;
    pulse(s);
    t.capture_dr = 1'h0;
    t.shift_dr = 1'h1;
    tap = t;
    for (int i = 0; i < n; i++) begin
      tdi = din[i];
      pulse(dout[i]);
    end
    t.shift_dr = 1'h0;
    tap = t;
    tdi = ~tdi; // Released data line must not keep its last level.
    pulse(s);
    // The last state stands until the next task moves the controller on.
    if (upd) begin
      t.update_dr = 1'h1;
      tap = t;
      pulse(s);
    end
  endtask
  // One pass through Run-Test/Idle, used only after commands.
  task automatic exec();
    logic      s;
    jpdr_tap_t t;
    t = tap;
    t.update_dr = 1'h0;
    t.run_idle = 1'h1;
    tap = t;
    pulse(s);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import jpdr_pkg::*;;
  logic          clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1;
  logic          cmd_ready = 1'h0, tck, tdi, tdo, tdo_oe, cmd_valid;
  logic          cmd_exec, pg_wr, pg_rd, core_reset, prog_enabled;
  logic [1:0]    tout_sel = 2'h0;
  logic [14:0]   cmd_data, cmd_result = 15'h0000, q_cmd[$], q_pg[$];
  logic [6:0]    pg_raddr;
  logic [7:0]    pg_rdata = 8'h00, pb;
  logic [1039:0] din, dout;
  jpdr_tap_t     tap;
  jpdr_byte_t    pg_wbyte;
  int            n_fail = 0, n_checks = 0, seed = 4, k, n_exec = 0;

  jpdr_core #(.TOUT1_CYC(30), .TOUT2_CYC(40)) u_dut (.clk_sys, .reset_n,
    .clk_en, .tck, .tdi, .tap, .tdo, .tdo_oe, .tout_sel, .cmd_valid,
    .cmd_ready, .cmd_data, .cmd_exec, .cmd_result, .pg_wr, .pg_rd, .pg_wbyte,
    .pg_raddr, .pg_rdata, .core_reset, .prog_enabled);
  jpdr_host u_host (.tck, .tdi, .tap, .tdo);

  // The system clock runs at 100 MHz; page bytes are a function of address.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) #1 pg_rdata = {pg_raddr, 1'h1} ^ 8'h5A;

  task automatic chk(input string nm, input logic [14:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // A wait that runs out of cycles ends the run as a failure.
  task automatic guard(input int c, lim);
    if (c == lim) begin
      n_fail++;
      finish_test();
    end
    @(posedge clk_sys);
    #1;
  endtask

  // Each accepted command or page write takes the oldest note.
  always @(posedge clk_sys) begin
    if (cmd_valid === 1'h1 && cmd_ready === 1'h1)
      chk("cmd_data", cmd_data, q_cmd.size() ? q_cmd.pop_front() : 'x);
    if (pg_wr === 1'h1)
      chk("pg_wbyte", pg_wbyte, q_pg.size() ? q_pg.pop_front() : 'x);
    // Execute pulses are counted and compared once all seventeen commands are scanned.
    if (cmd_exec === 1'h1)
      n_exec++;
  end

  initial begin
    repeat (4) guard(0, 1);
    reset_n = 1'h1;
    repeat (4) guard(0, 1);
    chk("prog_enabled", prog_enabled, 15'h0000);
    // Reset bit acts before any update; release waits out each time-out.
    for (k = 0; k < 3; k++) begin
      tout_sel = k[1:0];
      u_host.scan(JPDR_IR_RESET, 1, 1'h0, 1040'h1, dout);
      chk("core_reset", core_reset, 15'h0001);
      u_host.scan(JPDR_IR_RESET, 1, 1'h0, 1040'h0, dout);
      chk("core_reset", core_reset, 15'(k != 0));
      for (int c = 0; core_reset !== 1'h0; c++)
        guard(c, 60);
    end
    $display("test reset_bit done");
    // One bit off the signature stays locked; zero locks again.
    for (k = 0; k < 3; k++) begin
      din = k == 1 ? JPDR_SIGNATURE : (k == 0 ? 16'h2370 : 16'h0000);
      u_host.scan(JPDR_IR_UNLOCK, 16, 1'h1, din, dout);
      chk("prog_enabled", prog_enabled, 15'(k == 1));
    end
    $display("test unlock done");
    // Overfill the command buffer while the far side stalls.
    for (k = 0; k < 17; k++) begin
      cmd_result = 15'($random(seed));
      din = 1040'($random(seed));
      u_host.scan(JPDR_IR_COMMAND, 15, 1'h1, din, dout);
      chk("cmd_shift_out", dout[14:0], cmd_result);
      if (k < 16)
        q_cmd.push_back(din[14:0]);
      u_host.exec();
    end
    // The dropped seventeenth command must not be executed.
    chk("cmd_exec", 15'(n_exec), 15'h0010);
    for (k = 0; q_cmd.size() != 0; k++) begin
      guard(k, 2000);
      cmd_ready = 1'($random(seed));
    end
    cmd_ready = 1'h1;
    repeat (4) guard(0, 1);
    chk("cmd_valid", cmd_valid, 15'h0000);
    $display("test command done");
    // Page load: each byte lands in order from byte zero, update ignored.
    for (k = 0; k < 1024; k += 32)
      din[k +: 32] = $random(seed);
    for (k = 0; k < 128; k++)
      q_pg.push_back({k[6:0], din[8 * k +: 8]});
    u_host.scan(JPDR_IR_PLOAD, 1024, 1'h1, din, dout);
    chk("pg_left", 15'(q_pg.size()), 15'h0000);
    $display("test page_load done");
    // Page read: eight fill bits, then bytes in order; tdi is noise.
    u_host.scan(JPDR_IR_PREAD, 1032, 1'h1, ~din, dout);
    chk("pread_fill", 15'(dout[7:0]), 15'h0000);
    for (k = 0; k < 128; k++) begin
      pb = {k[6:0], 1'h1} ^ 8'h5A;
      chk("pread_byte", 15'(dout[8 + 8 * k +: 8]), 15'(pb));
    end
    $display("test page_read done");
    finish_test();
  end
endmodule
`default_nettype wire
